/* rtl/sol_pkg.sv */
// Constants shared by the secured OTP lock control block.
package sol_pkg;
    // ========================================================================
    // Serial opcodes
    localparam logic [7:0] OP_WR_SEC  = 8'h2f;
    localparam logic [7:0] OP_RD_SEC  = 8'h2b;
    localparam logic [7:0] OP_ENTER   = 8'hb1;
    localparam logic [7:0] OP_EXIT    = 8'hc1;
    localparam logic [7:0] OP_READ    = 8'h03;
    localparam logic [7:0] OP_PROG    = 8'h02;
    localparam logic [7:0] OP_WREN    = 8'h06;
    // ========================================================================
    // OTP area map
    localparam int          OTP_AW     = 9;
    localparam int          OTP_DEPTH  = 512;
    localparam logic [23:0] SN_LAST    = 24'h00000f;
    localparam logic [23:0] CUST_FIRST = 24'h000010;
    localparam logic [23:0] OTP_LAST   = 24'h0001ff;
    localparam logic [7:0]  ERASED     = 8'hff;
    // ========================================================================
    // Security register layout and reset values
    localparam int         SEC_FACT_BIT = 0;
    localparam int         SEC_CUST_BIT = 1;
    localparam int         SEC_VOL_LSB  = 2;
    localparam logic [5:0] SEC_VOL_RST  = 6'h00;
    // ========================================================================
    // Wishbone register offsets and fields
    localparam logic [3:0] WB_FLOCK      = 4'h0;
    localparam logic [3:0] WB_STAT       = 4'h4;
    localparam int         STAT_OTP_BIT  = 8;
    localparam int         STAT_WEL_BIT  = 9;
    localparam int         STAT_BUSY_BIT = 10;
endpackage

/* rtl/sol_sync.sv */
// Two-flop synchroniser for pins that come from outside the clock domain.
`timescale 1ns/100ps
module sol_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    // ========================================================================
    // One flop pair per bit
    for (genvar g = 0; g < W; g++) begin : g_bit
        typedef struct packed {
            logic s1;
            logic s2;
        } sol_sync_s;
        sol_sync_s r, n;
        always_comb begin
            n.s1 = d_i[g];
            n.s2 = r.s1;
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                r <= '{s1: 1'b1, s2: 1'b1};
            end else begin
                r <= n;
            end
        end
        assign q_o[g] = r.s2;
    end
endmodule

/* rtl/sol_otp_mem.sv */
// Storage for the 4K-bit OTP area with a registered read port.
`timescale 1ns/100ps
module sol_otp_mem (
    // Clock
    input  wire logic                         clk_i,
    // Write port
    input  wire logic                         we_i,
    input  wire logic [sol_pkg::OTP_AW-1:0]   waddr_i,
    input  wire logic [7:0]                   wdata_i,
    // Read port
    input  wire logic [sol_pkg::OTP_AW-1:0]   raddr_i,
    output logic      [7:0]                   rdata_o
);
    // ========================================================================
    // Array, erased at start-up
    logic [7:0] mem [sol_pkg::OTP_DEPTH];
    initial begin
        for (int i = 0; i < sol_pkg::OTP_DEPTH; i++) begin
            mem[i] = sol_pkg::ERASED;
        end
    end
    // A one-time cell can only clear bits, so the new byte is ANDed in.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= mem[waddr_i] & wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

/* rtl/sol_otp_ctrl.sv */
// Command logic for the secured OTP area, its lock bits and OTP mode.
`timescale 1ns/100ps
module sol_otp_ctrl (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Serial link
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_sclk_i,
    input  wire logic        spi_mosi_i,
    output logic             spi_miso_o,
    output logic             spi_miso_oe_n_o,
    // Main array side
    output logic             otp_mode_o,
    output logic             array_wr_block_o,
    output logic             status_wr_block_o
);
    // ========================================================================
    // Types and state
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_CMD  = 9'h002,
        ST_ADDR = 9'h004,
        ST_RDAT = 9'h008,
        ST_PDAT = 9'h010,
        ST_SIN  = 9'h020,
        ST_SOUT = 9'h040,
        ST_END  = 9'h080,
        ST_IGN  = 9'h100
    } sol_st_e;

    typedef struct packed {
        sol_st_e     st;
        logic [7:0]  sh;
        logic [2:0]  bitcnt;
        logic [7:0]  cmd;
        logic [1:0]  acnt;
        logic [23:0] addr;
        logic [7:0]  dout;
        logic        oe_n;
        logic        otp_mode;
        logic        wel;
        logic        cust_lock;
        logic        fact_lock;
        logic [5:0]  vol;
        logic [7:0]  sdata;
        logic        sfull;
        logic        mwe;
        logic [8:0]  mwa;
        logic [7:0]  mwd;
        logic        sclk_q;
        logic        csn_q;
        logic        ack;
        logic [31:0] wdat;
    } sol_state_s;

    sol_state_s r, n;
    logic [2:0] pins_s;
    logic       csn_s;
    logic       sclk_s;
    logic       mosi_s;
    logic [7:0] rdata;
    logic       rise;
    logic       fall;
    logic       cs_fall;
    logic       cs_rise;
    logic [7:0] byte_in;
    logic [7:0] sec_reg;
    logic       in_otp;
    logic       wr_ok;
    logic       sec_commit;

    // ========================================================================
    // Pin synchroniser and OTP storage
    sol_sync #(.W(3)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({spi_cs_n_i, spi_sclk_i, spi_mosi_i}),
        .q_o   (pins_s)
    );
    assign {csn_s, sclk_s, mosi_s} = pins_s;

    sol_otp_mem u_mem (
        .clk_i   (clk_i),
        .we_i    (r.mwe),
        .waddr_i (r.mwa),
        .wdata_i (r.mwd),
        .raddr_i (r.addr[sol_pkg::OTP_AW-1:0]),
        .rdata_o (rdata)
    );

    // ========================================================================
    // Decode helpers
    assign rise    = sclk_s & ~r.sclk_q & ~csn_s;
    assign fall    = ~sclk_s & r.sclk_q & ~csn_s;
    assign cs_fall = ~csn_s & r.csn_q;
    assign cs_rise = csn_s & ~r.csn_q;
    assign byte_in = {r.sh[6:0], mosi_s};
    assign sec_reg = {r.vol, r.cust_lock, r.fact_lock};
    assign in_otp  = r.addr <= sol_pkg::OTP_LAST;
    // Serial field closes under factory lock; whole area under customer lock.
    assign wr_ok   = r.otp_mode & r.wel & ~r.cust_lock & in_otp
                   & ~(r.fact_lock & (r.addr <= sol_pkg::SN_LAST));
    // No write enable is looked at here, and OTP mode or the customer lock refuses it; the factory lock does not.
    assign sec_commit = cs_rise & (r.st == ST_SIN) & (r.bitcnt == 3'h0) & r.sfull
                      & ~r.otp_mode & ~r.cust_lock;

    // ========================================================================
    // Next state
    always_comb begin
        n        = r;
        n.mwe    = 1'b0;
        n.sclk_q = sclk_s;
        n.csn_q  = csn_s;
        n.ack    = wb_cyc_i & wb_stb_i & ~r.ack;
        if (cs_fall) begin
            n.st     = ST_CMD;
            n.bitcnt = 3'h0;
            n.sfull  = 1'b0;
            n.oe_n   = 1'b1;
        end else if (cs_rise) begin
            n.st   = ST_IDLE;
            n.oe_n = 1'b1;
            // The output rests high between frames, whatever the last reload left in it.
            n.dout = 8'hff;
            if (r.st == ST_PDAT) begin
                n.wel = 1'b0;
            end
            if (r.st == ST_END && r.bitcnt == 3'h0) begin
                unique case (r.cmd)
                    sol_pkg::OP_ENTER: n.otp_mode = 1'b1;
                    sol_pkg::OP_EXIT:  n.otp_mode = 1'b0;
                    default:           n.wel      = 1'b1;
                endcase
            end
            if (sec_commit) begin
                // Lock bit only ever ORs in, so it can never be cleared.
                n.cust_lock = r.cust_lock | r.sdata[sol_pkg::SEC_CUST_BIT];
                n.vol       = r.sdata[7:sol_pkg::SEC_VOL_LSB];
            end
        end else if (rise) begin
            n.sh     = byte_in;
            n.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == 3'h7) begin
                unique case (r.st)
                    ST_CMD: begin
                        n.cmd  = byte_in;
                        n.acnt = 2'h0;
                        if (byte_in == sol_pkg::OP_WR_SEC) begin
                            n.st = ST_SIN;
                        end else if (byte_in == sol_pkg::OP_RD_SEC) begin
                            n.st = ST_SOUT;
                        end else if (byte_in == sol_pkg::OP_ENTER
                                  || byte_in == sol_pkg::OP_EXIT
                                  || byte_in == sol_pkg::OP_WREN) begin
                            n.st = ST_END;
                        end else if ((byte_in == sol_pkg::OP_READ
                                   || byte_in == sol_pkg::OP_PROG) && r.otp_mode) begin
                            n.st = ST_ADDR;
                        end else begin
                            n.st = ST_IGN;
                        end
                    end
                    ST_ADDR: begin
                        n.addr = {r.addr[15:0], byte_in};
                        n.acnt = r.acnt + 2'h1;
                        if (r.acnt == 2'h2) begin
                            n.st = (r.cmd == sol_pkg::OP_READ) ? ST_RDAT : ST_PDAT;
                        end
                    end
                    ST_PDAT: begin
                        n.mwe       = wr_ok;
                        n.mwa       = r.addr[sol_pkg::OTP_AW-1:0];
                        n.mwd       = byte_in;
                        n.addr[7:0] = r.addr[7:0] + 8'h01;
                    end
                    ST_SIN: begin
                        n.sdata = byte_in;
                        n.sfull = 1'b1;
                        if (r.sfull) begin
                            n.st = ST_IGN;
                        end
                    end
                    ST_END: n.st = ST_IGN;
                    default: n.st = r.st;
                endcase
            end
        end else if (fall && (r.st == ST_RDAT || r.st == ST_SOUT)) begin
            if (r.bitcnt == 3'h0) begin
                n.oe_n = 1'b0;
                if (r.st == ST_SOUT) begin
                    n.dout = sec_reg;
                end else begin
                    n.dout = in_otp ? rdata : sol_pkg::ERASED;
                    n.addr = r.addr + 24'h000001;
                end
            end else begin
                n.dout = {r.dout[6:0], 1'b1};
            end
        end
        // Bus side: factory lock can be set, never cleared.
        if (n.ack && wb_we_i && wb_adr_i == sol_pkg::WB_FLOCK && wb_sel_i[0]
            && wb_dat_i[sol_pkg::SEC_FACT_BIT]) begin
            n.fact_lock = 1'b1;
        end
        n.wdat = 32'h0000_0000;
        if (n.ack && !wb_we_i) begin
            if (wb_adr_i == sol_pkg::WB_FLOCK) begin
                n.wdat[sol_pkg::SEC_FACT_BIT] = r.fact_lock;
            end else if (wb_adr_i == sol_pkg::WB_STAT) begin
                n.wdat[7:0]                     = sec_reg;
                n.wdat[sol_pkg::STAT_OTP_BIT]  = r.otp_mode;
                n.wdat[sol_pkg::STAT_WEL_BIT]  = r.wel;
                n.wdat[sol_pkg::STAT_BUSY_BIT] = (r.st != ST_IDLE);
            end
        end
    end

    // ========================================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '{st: ST_IDLE, sh: 8'h00, bitcnt: 3'h0, cmd: 8'h00, acnt: 2'h0,
                   addr: 24'h000000, dout: 8'hff, oe_n: 1'b1, otp_mode: 1'b0,
                   wel: 1'b0, cust_lock: 1'b0, fact_lock: 1'b0,
                   vol: sol_pkg::SEC_VOL_RST, sdata: 8'h00, sfull: 1'b0,
                   mwe: 1'b0, mwa: 9'h000, mwd: 8'hff, sclk_q: 1'b1,
                   csn_q: 1'b1, ack: 1'b0, wdat: 32'h0000_0000};
        end else begin
            r <= n;
        end
    end

    // ========================================================================
    // Outputs
    assign spi_miso_o        = r.dout[7];
    assign spi_miso_oe_n_o   = r.oe_n;
    assign otp_mode_o        = r.otp_mode;
    assign array_wr_block_o  = r.otp_mode;
    assign status_wr_block_o = r.otp_mode;
    assign wb_dat_o          = r.wdat;
    assign wb_ack_o          = r.ack;

    // ========================================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_enter;
        cs_rise && r.st == ST_END && r.bitcnt == 3'h0 && r.cmd == sol_pkg::OP_ENTER;
    endsequence
    sequence s_exit;
        cs_rise && r.st == ST_END && r.bitcnt == 3'h0 && r.cmd == sol_pkg::OP_EXIT;
    endsequence
    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    a_cust_sticky:   assert property (r.cust_lock |=> r.cust_lock)
        else $error("customer lock cleared");
    a_fact_sticky:   assert property (r.fact_lock |=> r.fact_lock)
        else $error("factory lock cleared");
    a_sec_set_lock:  assert property (sec_commit && r.sdata[1] && !r.wel |=> r.cust_lock)
        else $error("security write did not set lock without write enable");
    a_sec_boundary:  assert property (cs_rise && r.st == ST_SIN && r.bitcnt != 3'h0
                                      |=> $stable(sec_reg[7:1]))
        else $error("security write taken off byte boundary");
    a_sec_otp_ign:   assert property (r.otp_mode && !r.fact_lock |=> $stable(sec_reg[7:1])
                                      or !$past(r.otp_mode))
        else $error("security register changed in OTP mode");
    a_lock_no_prog:  assert property (r.mwe |-> !r.cust_lock && r.otp_mode)
        else $error("OTP programmed while locked or outside OTP mode");
    a_sn_field:      assert property (r.mwe && r.fact_lock
                                      |-> {15'h0, r.mwa} >= sol_pkg::CUST_FIRST)
        else $error("serial field programmed under factory lock");
    a_array_block:   assert property (r.otp_mode |-> array_wr_block_o && status_wr_block_o)
        else $error("array writes not blocked in OTP mode");
    a_enter_otp:     assert property (s_enter |=> otp_mode_o [*2])
        else $error("enter command did not set OTP mode");
    a_exit_otp:      assert property (s_exit |=> !otp_mode_o && !array_wr_block_o)
        else $error("exit command did not leave OTP mode");
    a_sec_read:      assert property (fall && r.st == ST_SOUT && r.bitcnt == 3'h0
                                      |=> spi_miso_o == sec_reg[7] && !spi_miso_oe_n_o)
        else $error("security register not driven on read");
    a_wb_ack:        assert property (s_wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after request");
endmodule

/* tb/sol_spi_host.sv */
// Behavioural serial host that frames instructions into the OTP lock control block.
`timescale 1ns/100ps
module sol_spi_host (
    // Clock
    input  wire logic clk_i,
    // Serial link
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      mosi_o,
    input  wire logic miso_i,
    input  wire logic miso_oe_n_i
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end

    // ========================================================================
    // Frame transfer
    // Sends nb bits MSB first in mode 0; the serial clock rests low between frames.
    // A bit is read back late in the high phase, well after the device has shifted it.
    task automatic xfer(input int nb, input logic [63:0] tx, output logic [63:0] rx);
        rx = '0;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            // Data changes with the falling serial clock, for a 32 ns serial period.
            mosi_o <= tx[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            rx = {rx[62:0], (miso_oe_n_i === 1'b0) ? miso_i : ~rx[0]};
            sclk_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
        mosi_o <= ~mosi_o;
        repeat (8) @(posedge clk_i);
    endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the secured OTP lock control block.
`timescale 1ns/100ps
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  wb_adr = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic        wb_we = 1'b0;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        cs_n, sclk, mosi, miso, miso_oe_n;
    logic        otp_mode_o, array_wr_block_o, status_wr_block_o;
    int          mismatches = 0;
    int          compares = 0;

    always #2 clk_i = ~clk_i;

    sol_otp_ctrl u_sol_otp_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_sel_i(4'hf), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(miso_oe_n),
        .otp_mode_o(otp_mode_o), .array_wr_block_o(array_wr_block_o),
        .status_wr_block_o(status_wr_block_o)
    );

    sol_spi_host u_sol_spi_host (
        .clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi),
        .miso_i(miso), .miso_oe_n_i(miso_oe_n)
    );

    // ========================================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; waits for ack under a bound and takes data at that edge.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic spi(input int nb, input logic [63:0] tx);
        logic [63:0] rx;
        u_sol_spi_host.xfer(nb, tx, rx);
    endtask

    task automatic state_chk(input logic [7:0] sec, input logic otp);
        logic [63:0] rx;
        logic [31:0] d;
        u_sol_spi_host.xfer(16, {48'h0, sol_pkg::OP_RD_SEC, 8'h00}, rx);
        chk({24'h0, rx[7:0]}, {24'h0, sec});
        bus(1'b0, sol_pkg::WB_STAT, 32'h0, d);
        chk({21'h0, d[10:0]}, {21'h0, 2'b00, otp, sec});
        chk({29'h0, otp_mode_o, array_wr_block_o, status_wr_block_o}, {29'h0, {3{otp}}});
    endtask

    task automatic prog(input logic wren, input logic [23:0] a, input logic [15:0] d);
        if (wren) spi(8, {56'h0, sol_pkg::OP_WREN});
        spi(48, {16'h0, sol_pkg::OP_PROG, a, d});
    endtask

    task automatic otp_rd(input logic [23:0] a, input logic [15:0] exp);
        logic [63:0] rx;
        u_sol_spi_host.xfer(48, {16'h0, sol_pkg::OP_READ, a, 16'h0}, rx);
        chk({16'h0, rx[15:0]}, {16'h0, exp});
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ========================================================================
    // Tests
    initial begin
        logic [31:0] d;
        logic [63:0] rx;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({30'h0, miso, miso_oe_n}, 32'h3);
        state_chk(8'h00, 1'b0);
        bus(1'b1, 4'h8, 32'hffff_ffff, d);
        bus(1'b0, 4'h8, 32'h0, d);
        chk(d, 32'h0);
        spi(12, {52'h0, sol_pkg::OP_WR_SEC, 4'hf});
        state_chk(8'h00, 1'b0);
        spi(24, {40'h0, sol_pkg::OP_WR_SEC, 16'hfefe});
        state_chk(8'h00, 1'b0);
        spi(16, {48'h0, sol_pkg::OP_WR_SEC, 8'hfd});
        state_chk(8'hfc, 1'b0);
        spi(9, {55'h0, sol_pkg::OP_ENTER, 1'b0});
        state_chk(8'hfc, 1'b0);
        spi(8, {56'h0, sol_pkg::OP_ENTER});
        state_chk(8'hfc, 1'b1);
        spi(16, {48'h0, sol_pkg::OP_WR_SEC, 8'h02});
        state_chk(8'hfc, 1'b1);
        prog(1'b0, 24'h000020, 16'h0000);
        otp_rd(24'h000020, 16'hffff);
        prog(1'b1, 24'h000010, 16'ha53c);
        otp_rd(24'h000010, 16'ha53c);
        prog(1'b1, 24'h0001fe, 16'h1234);
        otp_rd(24'h0001fe, 16'h1234);
        otp_rd(24'h0001ff, 16'h34ff);
        bus(1'b1, sol_pkg::WB_FLOCK, 32'h1, d);
        state_chk(8'hfd, 1'b1);
        prog(1'b1, 24'h00000e, 16'h0000);
        otp_rd(24'h00000e, 16'hffff);
        prog(1'b1, 24'h000012, 16'h5a5a);
        otp_rd(24'h000012, 16'h5a5a);
        spi(8, {56'h0, sol_pkg::OP_EXIT});
        state_chk(8'hfd, 1'b0);
        spi(16, {48'h0, sol_pkg::OP_WR_SEC, 8'h02});
        state_chk(8'h03, 1'b0);
        spi(16, {48'h0, sol_pkg::OP_WR_SEC, 8'hfc});
        bus(1'b1, sol_pkg::WB_FLOCK, 32'h0, d);
        state_chk(8'h03, 1'b0);
        spi(8, {56'h0, sol_pkg::OP_ENTER});
        prog(1'b1, 24'h000014, 16'h0000);
        otp_rd(24'h000014, 16'hffff);
        otp_rd(24'h000010, 16'ha53c);
        spi(8, {56'h0, sol_pkg::OP_EXIT});
        u_sol_spi_host.xfer(32, {32'h0, sol_pkg::OP_RD_SEC, 24'h0}, rx);
        chk({8'h0, rx[23:0]}, 32'h0003_0303);
        chk({30'h0, miso, miso_oe_n}, 32'h3);
        results();
    end

    // Roughly 9k cycles are needed; the watchdog allows several times that.
    initial begin
        #200000;
        mismatches++;
        results();
    end
endmodule
